// ### sim/three_wire_latch_loader_test.sv
`timescale 1ns/1ps
`default_nettype none
module three_wire_latch_loader_test;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic req_valid_in = 1'b0;
    logic [23:0] req_word_in = 24'h000000;
    logic req_ready_out, done_out, modulator_restart_out;
    logic [23:0] latch0_out, latch1_out, latch2_out, latch3_out;
    logic [23:0] exp_q [4];
    logic [3:0] latch_written_out, seen;
    logic [4:0] bit_count_out;
    int failures = 0;
    int cmp_count = 0;
    int restarts = 0;
    three_wire_if link_bus ();
    three_wire_host three_wire_host_inst (.clk_in(clk_in), .rst_in(rst_in),
        .link(link_bus.host_end), .req_valid_in(req_valid_in),
        .req_word_in(req_word_in), .req_ready_out(req_ready_out),
        .done_out(done_out));
    three_wire_device three_wire_device_inst (.clk_in(clk_in),
        .rst_in(rst_in), .link(link_bus.device_end),
        .latch0_out(latch0_out), .latch1_out(latch1_out),
        .latch2_out(latch2_out), .latch3_out(latch3_out),
        .latch_written_out(latch_written_out),
        .modulator_restart_out(modulator_restart_out),
        .bit_count_out(bit_count_out));
    three_wire_checker three_wire_checker_inst (.clk_in(clk_in),
        .rst_in(rst_in), .shift_clock(link_bus.shift_clock),
        .serial_input_bits(link_bus.serial_input_bits),
        .word_commit_strobe(link_bus.word_commit_strobe),
        .latch_written_out(latch_written_out),
        .modulator_restart_out(modulator_restart_out));
    // 4 ns system clock
    always #2 clk_in = ~clk_in;
    // pulses are one cycle wide, so gather them at every edge
    always @(posedge clk_in)
    begin
        seen = seen | latch_written_out;
        if (modulator_restart_out === 1'b1)
            restarts++;
    end
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: got %h expected %h",
                $time, got, exp);
        end
    endtask
    task automatic stop_test();
        if (failures == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // one host request, held until taken, then waits for completion
    task automatic send(input logic [23:0] w);
        int n;
        n = 0;
        @(negedge clk_in);
        req_valid_in = 1'b1;
        req_word_in = w;
        seen = 4'h0;
        while (req_ready_out !== 1'b1 && n < 100)
        begin
            @(negedge clk_in);
            n++;
        end
        @(negedge clk_in);
        req_valid_in = 1'b0;
        while (done_out !== 1'b1 && n < 2000)
        begin
            @(negedge clk_in);
            n++;
        end
        chk({23'h0, done_out}, 24'h000001);
        exp_q[w[1:0]] = w;
        chk({20'h0, seen}, 24'h1 << w[1:0]);
        chk({19'h0, bit_count_out}, 24'h000000);
    endtask
    // watchdog: six words take under 3000 cycles
    initial
    begin
        repeat (30000) @(posedge clk_in);
        failures++;
        stop_test();
    end
    initial
    begin
        repeat (12) @(negedge clk_in);
        rst_in = 1'b0;
        for (int i = 0; i < 4; i++)
            send({8'hc1 + 8'(i), 14'h2d96, 2'(i)});
        send(24'h800000);
        send(24'h3ffffc);
        chk(latch0_out, exp_q[0]);
        chk(latch1_out, exp_q[1]);
        chk(latch2_out, exp_q[2]);
        chk(latch3_out, exp_q[3]);
        chk(24'(restarts), 24'h000003);
        stop_test();
    end
endmodule
`default_nettype wire

// ### sim/three_wire_properties.sv
`timescale 1ns/1ps
`default_nettype none
module three_wire_checker (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic shift_clock,
    input wire logic serial_input_bits,
    input wire logic word_commit_strobe,
    input wire logic [3:0] latch_written_out,
    input wire logic modulator_restart_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    logic [5:0] rise_cnt_q;
    // rises since the last strobe; a short word must not pass unseen
    always_ff @(posedge clk_in or posedge rst_in)
        if (rst_in)
            rise_cnt_q <= 6'h00;
        else if (word_commit_strobe)
            rise_cnt_q <= 6'h00;
        else if ($rose(shift_clock))
            rise_cnt_q <= rise_cnt_q + 6'h01;
    AST_SCLK_HIGH: assert property (
        $rose(shift_clock) |=> shift_clock[*6])
        else $error("shift clock high too short");
    AST_SCLK_LOW: assert property (
        $fell(shift_clock) |=> !shift_clock[*6])
        else $error("shift clock low too short");
    AST_DATA_SETUP: assert property (
        $rose(shift_clock) |-> $stable(serial_input_bits))
        else $error("data moved at clock rise");
    AST_DATA_HOLD: assert property (
        shift_clock && $past(shift_clock) |-> $stable(serial_input_bits))
        else $error("data moved while clock high");
    AST_STROBE_LOW: assert property (
        $rose(shift_clock) |-> !word_commit_strobe)
        else $error("strobe high while shifting");
    AST_STROBE_PULSE: assert property (
        $rose(word_commit_strobe) |=>
            word_commit_strobe[*6] ##1 !word_commit_strobe)
        else $error("strobe pulse width wrong");
    AST_WORD_LEN: assert property (
        $rose(word_commit_strobe) |-> rise_cnt_q == 6'h18)
        else $error("word not 24 bits");
    AST_COMMIT: assert property (
        $rose(word_commit_strobe) |-> ##[1:8] latch_written_out != 4'h0)
        else $error("no latch written after strobe");
    AST_ONE_LATCH: assert property (
        latch_written_out != 4'h0 |-> $onehot(latch_written_out))
        else $error("several latches written");
    AST_RESTART: assert property (
        latch_written_out[0] |-> ##[0:1] modulator_restart_out)
        else $error("no modulator restart");
    // main scenarios reached
    cover property ($rose(word_commit_strobe));
    cover property (modulator_restart_out);
    cover property (latch_written_out[3]);
endmodule
`default_nettype wire

// ### verilog/latch_loader_pkg.sv
`default_nettype none
package latch_loader_pkg;
    localparam int unsigned WORD_BITS = 24;
    localparam int unsigned BYTE_BITS = 8;
    localparam int unsigned BYTES_PER_WORD = 3;
    localparam int unsigned SEL_BITS = 2;
    localparam int unsigned LATCH_COUNT = 4;
    localparam int unsigned BIT_CNT_W = 5;
    // latch select position in the word (least significant bits)
    localparam int unsigned SEL_LSB = 0;
    // the latch index whose write restarts the fractional modulator
    localparam logic [1:0] FREQ_LATCH_SEL = 2'h0;
    // system clock and link clock limits
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned SCLK_MAX_MHZ = 20;
    // half period of the generated shift clock, rounded up so the rate stays
    // at or below the maximum
    localparam int unsigned SCLK_HALF_CYC =
        (CLK_MHZ + 2 * SCLK_MAX_MHZ - 1) / (2 * SCLK_MAX_MHZ);
    localparam int unsigned DIV_W = 4;
    localparam logic [23:0] WORD_RESET = 24'h000000;
endpackage
`default_nettype wire

// ### verilog/three_wire_device.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - capture one data bit per shift clock rise
// - strobe high moves word into selected latch
// - host keeps shift clock at most 20 MHz
// - host holds strobe low while shifting
// - each latch write is 24 bits
// - host raises strobe after last byte
// - host shifts like phase zero master
// - modulator restarts identically after frequency write
module three_wire_device (
    input wire logic clk_in,
    input wire logic rst_in,
    three_wire_if.device_end link,
    output logic [23:0] latch0_out,
    output logic [23:0] latch1_out,
    output logic [23:0] latch2_out,
    output logic [23:0] latch3_out,
    output logic [3:0] latch_written_out,
    output logic modulator_restart_out,
    output logic [4:0] bit_count_out
);
    logic [2:0] sclk_sync_q;
    logic [2:0] data_sync_q;
    logic [2:0] strobe_sync_q;
    logic sclk_level_q;
    logic data_level_q;
    logic strobe_level_q;
    logic [23:0] shift_q;
    logic [4:0] count_q;
    logic [23:0] latch_q [latch_loader_pkg::LATCH_COUNT];
    logic [3:0] written_q;
    logic restart_q;
    logic sclk_rise;
    logic strobe_rise;
    logic [1:0] sel;

    // three stage synchronisers; a level counts once stages two and three agree
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            sclk_sync_q <= 3'h0;
            data_sync_q <= 3'h0;
            strobe_sync_q <= 3'h0;
            sclk_level_q <= 1'b0;
            data_level_q <= 1'b0;
            strobe_level_q <= 1'b0;
        end
        else
        begin
            sclk_sync_q <= {sclk_sync_q[1:0], link.shift_clock};
            data_sync_q <= {data_sync_q[1:0], link.serial_input_bits};
            strobe_sync_q <= {strobe_sync_q[1:0], link.word_commit_strobe};
            if (sclk_sync_q[1] == sclk_sync_q[2])
                sclk_level_q <= sclk_sync_q[2];
            if (data_sync_q[1] == data_sync_q[2])
                data_level_q <= data_sync_q[2];
            if (strobe_sync_q[1] == strobe_sync_q[2])
                strobe_level_q <= strobe_sync_q[2];
        end
    end

    // data is filtered the same way, so it lines up with the clock edge
    assign sclk_rise = (sclk_sync_q[2] == sclk_sync_q[1]) && sclk_sync_q[2]
        && !sclk_level_q;
    assign strobe_rise = (strobe_sync_q[2] == strobe_sync_q[1])
        && strobe_sync_q[2] && !strobe_level_q;
    assign sel = shift_q[latch_loader_pkg::SEL_LSB +: 2];

    // input shift register, msb enters first and ends at the top
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            shift_q <= latch_loader_pkg::WORD_RESET;
            count_q <= '0;
        end
        else if (strobe_rise)
            count_q <= '0;
        else if (sclk_rise)
        begin
            shift_q <= {shift_q[22:0], data_level_q};
            if (count_q != 5'h1f)
                count_q <= count_q + 1'b1;
        end
    end

    // commit on the strobe rise; only the last 24 bits matter, so a longer
    // burst still commits its final word
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            for (int i = 0; i < latch_loader_pkg::LATCH_COUNT; i++)
                latch_q[i] <= latch_loader_pkg::WORD_RESET;
            written_q <= 4'h0;
            restart_q <= 1'b0;
        end
        else
        begin
            written_q <= 4'h0;
            restart_q <= 1'b0;
            if (strobe_rise)
            begin
                latch_q[sel] <= shift_q;
                written_q[sel] <= 1'b1;
                // deterministic modulator start on each frequency write
                restart_q <= (sel == latch_loader_pkg::FREQ_LATCH_SEL);
            end
        end
    end

    assign latch0_out = latch_q[0];
    assign latch1_out = latch_q[1];
    assign latch2_out = latch_q[2];
    assign latch3_out = latch_q[3];
    assign latch_written_out = written_q;
    assign modulator_restart_out = restart_q;
    assign bit_count_out = count_q;
endmodule
`default_nettype wire

// ### verilog/three_wire_host.sv
`timescale 1ns/1ps
`default_nettype none
module three_wire_host (
    input wire logic clk_in,
    input wire logic rst_in,
    three_wire_if.host_end link,
    input wire logic req_valid_in,
    input wire logic [23:0] req_word_in,
    output logic req_ready_out,
    output logic done_out
);
    typedef enum logic [1:0] {IDLE, LOW_PH, HIGH_PH, COMMIT} host_state_t;
    host_state_t state_q;
    logic [latch_loader_pkg::DIV_W-1:0] div_q;
    logic [23:0] word_q;
    logic [latch_loader_pkg::BIT_CNT_W-1:0] bits_q;
    logic tick;
    logic sclk_q;
    logic strobe_q;
    logic done_q;

    localparam logic [latch_loader_pkg::DIV_W-1:0] HALF_LAST =
        latch_loader_pkg::DIV_W'(latch_loader_pkg::SCLK_HALF_CYC - 1);
    localparam logic [latch_loader_pkg::BIT_CNT_W-1:0] LAST_BIT =
        latch_loader_pkg::BIT_CNT_W'(latch_loader_pkg::WORD_BITS - 1);

    // divider gives one enable per half period of the shift clock
    assign tick = (div_q == HALF_LAST);
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            div_q <= '0;
        else if (state_q == IDLE || tick)
            div_q <= '0;
        else
            div_q <= div_q + 1'b1;
    end

    assign req_ready_out = (state_q == IDLE);

    // shift sequencer: low half drives data, high half gives the rising edge
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state_q <= IDLE;
            word_q <= latch_loader_pkg::WORD_RESET;
            bits_q <= '0;
            sclk_q <= 1'b0;
            strobe_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            done_q <= 1'b0;
            unique case (state_q)
                IDLE:
                begin
                    sclk_q <= 1'b0;
                    if (req_valid_in)
                    begin
                        word_q <= req_word_in;
                        bits_q <= '0;
                        strobe_q <= 1'b0;
                        state_q <= LOW_PH;
                    end
                end
                LOW_PH:
                    if (tick)
                    begin
                        sclk_q <= 1'b1; // data was stable a half period
                        state_q <= HIGH_PH;
                    end
                HIGH_PH:
                    if (tick)
                    begin
                        sclk_q <= 1'b0;
                        word_q <= {word_q[22:0], 1'b0}; // msb first
                        if (bits_q == LAST_BIT) // 24 bits, three bytes
                            state_q <= COMMIT;
                        else
                        begin
                            bits_q <= bits_q + 1'b1;
                            state_q <= LOW_PH;
                        end
                    end
                COMMIT:
                    if (tick)
                    begin
                        if (strobe_q)
                        begin
                            strobe_q <= 1'b0;
                            done_q <= 1'b1;
                            state_q <= IDLE;
                        end
                        else
                            strobe_q <= 1'b1;
                    end
            endcase
        end
    end

    // half period of 7 cycles at 4 ns keeps the clock near 17.9 MHz
    assign link.shift_clock = sclk_q;
    assign link.serial_input_bits = word_q[23];
    assign link.word_commit_strobe = strobe_q;
    assign done_out = done_q;
endmodule
`default_nettype wire

// ### verilog/three_wire_if.sv
`timescale 1ns/1ps
`default_nettype none
interface three_wire_if;
    logic shift_clock;
    logic serial_input_bits;
    logic word_commit_strobe;
    modport host_end (
        output shift_clock,
        output serial_input_bits,
        output word_commit_strobe
    );
    modport device_end (
        input shift_clock,
        input serial_input_bits,
        input word_commit_strobe
    );
endinterface
`default_nettype wire
